// [design/ags_pkg.sv]
package ags_pkg;
	localparam int NUM_CH     = 8;
	localparam int ADC_W      = 13;
	localparam int WORD_W     = 14;
	localparam int GAIN_W     = 4;
	localparam int COEF_W     = 13;
	localparam int GAIN_FRAC  = 10;
	localparam int SPI_FRAME  = 24;
	localparam int FIFO_DEPTH = 16;
	localparam int SYNC_LEN   = 3;

	// Register offsets
	localparam logic [7:0] REG_PATTERN_MODE = 8'h25;
	localparam logic [7:0] REG_CUSTOM_ONE   = 8'h26;
	localparam logic [7:0] REG_GAIN_A       = 8'h2a;
	localparam logic [7:0] REG_GAIN_B       = 8'h2b;
	localparam logic [7:0] REG_PHASE        = 8'h42;
	localparam logic [7:0] REG_MODE         = 8'h46;
	localparam logic [7:0] REG_WIDTH        = 8'h53;
	localparam logic [7:0] REG_STATUS       = 8'h70;

	// Field positions
	localparam int READ_BIT      = 7;
	localparam int PHASE_LSB     = 5;
	localparam int TWOS_BIT      = 2;
	localparam int MSB_FIRST_BIT = 3;
	localparam int SDR_BIT       = 4;
	localparam int FALL_SDR_BIT  = 13;
	localparam int SINGLE_PAT_BIT = 4;
	localparam int CUSTOM_LSB    = 2;
	localparam int WIDTH_BIT     = 1;

	// Reset values
	localparam logic [15:0] PHASE_RST = 16'h0040;
	localparam logic [15:0] ZERO_RST  = 16'h0000;

	// Word lengths and frame clock halves
	localparam logic [3:0] BITS_NARROW = 4'hc;
	localparam logic [3:0] BITS_WIDE   = 4'he;
	localparam logic [3:0] HALF_NARROW = 4'h6;
	localparam logic [3:0] HALF_WIDE   = 4'h7;
	localparam logic [13:0] MSB_NARROW = 14'h0800;
	localparam logic [13:0] MSB_WIDE   = 14'h2000;
	localparam logic [3:0] GAIN_MAX_CODE = 4'hc;
endpackage

// [design/ags_fifo.sv]
module ags_fifo #(
	parameter int WIDTH = 112,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic [AW:0]      count_d;
	logic             ready_q;
	wire              push = in_valid && ready_q;
	wire              pop  = out_valid && out_ready;

	assign count_d   = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_valid = count_q != '0;
	assign in_ready  = ready_q;
	assign out_data  = mem_q[rd_ptr_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// Ready is registered so the source sees a clean flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
			ready_q  <= 1'b0;
		end else begin
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
			count_q  <= count_d;
			ready_q  <= count_d != (AW+1)'(DEPTH);
		end
	end
endmodule // ags_fifo

// [design/ags_format_top.sv]
// Notes on behaviour
// [R1] Each channel gets its own purely digital gain, which is 0 dB after reset.
// [R2] A 4-bit gain code n applies n dB, from 0 dB to 12 dB.
// [R3] Channels one to four sit low to high in the first gain register, five to eight high to low in the second.
// [R4] Software must not write gain codes above twelve.
// [R5] After reset the link runs double data rate with a bit clock edge centred in each bit, rising and falling in alternate bits.
// [R6] A 2-bit phase field shifts the bit clock against frame and data, resetting to binary 10, 90 degrees.
// [R7] The phase field lives in bits 6:5 of register 0x42.
// [R8] Single data rate doubles the bit clock to twelve times the sample clock; with 14-bit words the code gives fourteen times.
// [R9] The single data rate enable is bit 4 of register 0x46 and resets to double data rate.
// [R10] In single data rate one chosen edge, rising by default, sits mid-window for capture.
// [R11] Software should avoid single data rate above 40 MSPS.
// [R12] Words are offset binary unless two's complement mode inverts the top bit.
// [R13] By default the least significant bit follows the frame clock rising edge, then ascending order.
// [R14] Most-significant-first mode reverses the serial bit order.
// [R15] The 13-bit result goes out as 12 bits without its lowest bit or 14 bits with a zero appended.
// [R16] The custom pattern word follows the same bit order as conversion data.
module ags_format_top #(
	parameter int FIFO_DEPTH = ags_pkg::FIFO_DEPTH
) (
	input  wire logic                                        clk,
	input  wire logic                                        sys_rst,
	input  wire logic                                        ser_clk,
	input  wire logic                                        spi_sclk,
	input  wire logic                                        spi_sdata,
	input  wire logic                                        spi_cs_n,
	output logic                                             spi_sdout,
	input  wire logic                                        sample_valid,
	output logic                                             sample_ready,
	input  wire logic [ags_pkg::NUM_CH*ags_pkg::ADC_W-1:0]  sample_data,
	output logic                                             bit_clock_out,
	output logic                                             frame_clock_positive,
	output logic [ags_pkg::NUM_CH-1:0]                      lane_out
);
	localparam int NC  = ags_pkg::NUM_CH;
	localparam int AW  = ags_pkg::ADC_W;
	localparam int WW  = ags_pkg::WORD_W;
	localparam int BUS = NC * WW;
	localparam int PW  = AW + ags_pkg::COEF_W + 1;

	function automatic logic [ags_pkg::COEF_W-1:0] gain_coef(input logic [3:0] code);
		unique case (code)
			4'h0: gain_coef = 13'h0400;
			4'h1: gain_coef = 13'h047d;
			4'h2: gain_coef = 13'h0509;
			4'h3: gain_coef = 13'h05a6;
			4'h4: gain_coef = 13'h0657;
			4'h5: gain_coef = 13'h071d;
			4'h6: gain_coef = 13'h07fb;
			4'h7: gain_coef = 13'h08f5;
			4'h8: gain_coef = 13'h0a0c;
			4'h9: gain_coef = 13'h0b46;
			4'ha: gain_coef = 13'h0ca6;
			4'hb: gain_coef = 13'h0e31;
			default: gain_coef = 13'h0fed;
		endcase
	endfunction

	// ---------------- Serial control port, clk domain ----------------
	logic [2:0]  sclk_s_q;
	logic [2:0]  sdat_s_q;
	logic [2:0]  cs_s_q;
	logic        sclk_lvl_q;
	logic        cs_lvl_q;
	logic [4:0]  spi_cnt_q;
	logic [22:0] spi_sh_q;
	logic [15:0] out_sh_q;
	logic        sdout_q;

	always_ff @(posedge clk) begin
		sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
		sdat_s_q <= {sdat_s_q[1:0], spi_sdata};
		cs_s_q   <= {cs_s_q[1:0], spi_cs_n};
	end

	wire        sclk_agree = sclk_s_q[1] == sclk_s_q[2];
	wire        cs_agree   = cs_s_q[1] == cs_s_q[2];
	wire        sclk_rise  = sclk_agree && sclk_s_q[2] && !sclk_lvl_q;
	wire        sclk_fall  = sclk_agree && !sclk_s_q[2] && sclk_lvl_q;
	wire        spi_sel    = !cs_lvl_q;
	wire [23:0] spi_word   = {spi_sh_q, sdat_s_q[2]};
	wire [7:0]  rd_addr    = spi_word[7:0];
	wire        wr_en      = spi_sel && sclk_rise && spi_cnt_q == 5'd23
	                         && !spi_word[16+ags_pkg::READ_BIT];
	wire [7:0]  wr_addr    = spi_word[23:16];
	wire [15:0] wr_data    = spi_word[15:0];
	wire        rd_load    = spi_sel && sclk_rise && spi_cnt_q == 5'd7
	                         && rd_addr[ags_pkg::READ_BIT];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sclk_lvl_q <= 1'b0;
			cs_lvl_q   <= 1'b1;
		end else begin
			sclk_lvl_q <= sclk_agree ? sclk_s_q[2] : sclk_lvl_q;
			cs_lvl_q   <= cs_agree ? cs_s_q[2] : cs_lvl_q;
		end
	end

	// Frames of 24 bits may follow back to back while select stays low
	always_ff @(posedge clk) begin
		if (sys_rst || !spi_sel) begin
			spi_cnt_q <= '0;
		end else if (sclk_rise) begin
			spi_cnt_q <= (spi_cnt_q == 5'd23) ? 5'd0 : spi_cnt_q + 5'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			spi_sh_q <= '0;
		end else if (spi_sel && sclk_rise) begin
			spi_sh_q <= spi_word[22:0];
		end
	end

	// ---------------- Register file ----------------
	logic [15:0] gain_a_q;
	logic [15:0] gain_b_q;
	logic [15:0] phase_reg_q;
	logic [15:0] mode_reg_q;
	logic [15:0] pat_mode_q;
	logic [15:0] custom_one_q;
	logic [15:0] width_reg_q;
	logic        pend;
	logic        fifo_out_valid;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gain_a_q     <= ags_pkg::ZERO_RST; // R1
			gain_b_q     <= ags_pkg::ZERO_RST; // R1
			phase_reg_q  <= ags_pkg::PHASE_RST; // R6
			mode_reg_q   <= ags_pkg::ZERO_RST; // R9
			pat_mode_q   <= ags_pkg::ZERO_RST;
			custom_one_q <= ags_pkg::ZERO_RST;
			width_reg_q  <= ags_pkg::ZERO_RST;
		end else if (wr_en) begin
			gain_a_q     <= (wr_addr == ags_pkg::REG_GAIN_A) ? wr_data : gain_a_q;
			gain_b_q     <= (wr_addr == ags_pkg::REG_GAIN_B) ? wr_data : gain_b_q;
			phase_reg_q  <= (wr_addr == ags_pkg::REG_PHASE) ? wr_data : phase_reg_q; // R7
			mode_reg_q   <= (wr_addr == ags_pkg::REG_MODE) ? wr_data : mode_reg_q; // R9
			pat_mode_q   <= (wr_addr == ags_pkg::REG_PATTERN_MODE) ? wr_data : pat_mode_q;
			custom_one_q <= (wr_addr == ags_pkg::REG_CUSTOM_ONE) ? wr_data : custom_one_q;
			width_reg_q  <= (wr_addr == ags_pkg::REG_WIDTH) ? wr_data : width_reg_q;
		end
	end

	wire [15:0] status_w = {14'h0000, fifo_out_valid, pend};
	wire [7:0]  rd_sel   = rd_addr & 8'h7f;
	wire [15:0] rd_data  =
		(rd_sel == ags_pkg::REG_GAIN_A)       ? gain_a_q :
		(rd_sel == ags_pkg::REG_GAIN_B)       ? gain_b_q :
		(rd_sel == ags_pkg::REG_PHASE)        ? phase_reg_q :
		(rd_sel == ags_pkg::REG_MODE)         ? mode_reg_q :
		(rd_sel == ags_pkg::REG_PATTERN_MODE) ? pat_mode_q :
		(rd_sel == ags_pkg::REG_CUSTOM_ONE)   ? custom_one_q :
		(rd_sel == ags_pkg::REG_WIDTH)        ? width_reg_q :
		(rd_sel == ags_pkg::REG_STATUS)       ? status_w : 16'h0000;

	// Read data shifts out on falling edges, so the master samples on rising
	always_ff @(posedge clk) begin
		if (sys_rst || !spi_sel) begin
			out_sh_q <= '0;
			sdout_q  <= 1'b0;
		end else if (rd_load) begin
			out_sh_q <= rd_data;
		end else if (sclk_fall) begin
			sdout_q  <= out_sh_q[15];
			out_sh_q <= {out_sh_q[14:0], 1'b0};
		end
	end
	assign spi_sdout = sdout_q;

	wire       twos_en  = mode_reg_q[ags_pkg::TWOS_BIT];
	wire       msb_en   = mode_reg_q[ags_pkg::MSB_FIRST_BIT];
	wire       sdr_en   = mode_reg_q[ags_pkg::SDR_BIT];
	wire       fall_en  = mode_reg_q[ags_pkg::FALL_SDR_BIT];
	wire       pat_en   = pat_mode_q[ags_pkg::SINGLE_PAT_BIT];
	wire       wide_en  = width_reg_q[ags_pkg::WIDTH_BIT];
	wire [1:0] phase_w  = phase_reg_q[ags_pkg::PHASE_LSB +: 2]; // R7
	wire [13:0] custom_w = custom_one_q[ags_pkg::CUSTOM_LSB +: WW];

	// ---------------- Gain and formatting ----------------
	logic [3:0]    gain_code [NC];
	logic [AW-1:0] gained    [NC];
	logic [WW-1:0] fmt       [NC];
	logic [BUS-1:0] fifo_in;

	for (genvar ch = 0; ch < NC; ch++) begin : g_chan
		wire [AW-1:0]        raw    = sample_data[ch*AW +: AW];
		wire signed [AW-1:0] sval   = {~raw[AW-1], raw[AW-2:0]};
		wire signed [AW:0]   coef   = {1'b0, gain_coef(gain_code[ch])}; // R2
		wire signed [PW-1:0] prod   = sval * coef;
		wire signed [PW-1:0] scaled = prod >>> ags_pkg::GAIN_FRAC;
		wire                 hi     = scaled > 27'sh000_0fff;
		wire                 lo     = scaled < 27'sh7ff_f000;
		wire [AW-1:0]        sat    = hi ? 13'h0fff : lo ? 13'h1000 : scaled[AW-1:0];
		wire [WW-1:0]        data_w = wide_en ? {gained[ch], 1'b0}
		                                      : {2'b00, gained[ch][AW-1:1]}; // R15
		wire [WW-1:0]        flip   = wide_en ? ags_pkg::MSB_WIDE : ags_pkg::MSB_NARROW;
		wire [WW-1:0]        pat_w  = wide_en ? custom_w : {2'b00, custom_w[WW-1:2]};

		if (ch < 4) begin : g_low
			assign gain_code[ch] = gain_a_q[ch*4 +: 4]; // R3
		end else begin : g_high
			assign gain_code[ch] = gain_b_q[(7-ch)*4 +: 4]; // R3
		end
		assign gained[ch] = {~sat[AW-1], sat[AW-2:0]}; // R1
		assign fmt[ch]    = pat_en ? pat_w : (twos_en ? data_w ^ flip : data_w); // R12
		assign fifo_in[ch*WW +: WW] = fmt[ch];
	end

	// ---------------- Buffer and word handoff ----------------
	logic [BUS-1:0] fifo_out;
	logic [BUS-1:0] hold_q;
	logic           req_q;
	logic [2:0]     ack_s_q;
	logic           ack_lvl_q;
	logic           ack_q;
	wire            take = fifo_out_valid && !pend;

	ags_fifo #(
		.WIDTH (BUS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (take),
		.out_data  (fifo_out)
	);

	assign pend = req_q != ack_lvl_q;

	always_ff @(posedge clk) begin
		ack_s_q <= {ack_s_q[1:0], ack_q};
	end

	// Hold stays still until the link side acknowledges, so words cross whole
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hold_q    <= '0;
			req_q     <= 1'b0;
			ack_lvl_q <= 1'b0;
		end else begin
			ack_lvl_q <= (ack_s_q[1] == ack_s_q[2]) ? ack_s_q[2] : ack_lvl_q;
			if (take) begin
				hold_q <= fifo_out;
				req_q  <= !req_q;
			end
		end
	end

	// ---------------- Link side, ser_clk domain ----------------
	logic [2:0]     rst_s_q;
	logic           ser_rst_q;
	logic [5:0]     cfg_s1_q;
	logic [5:0]     cfg_s2_q;
	logic [5:0]     cfg_s3_q;
	logic [5:0]     cfg_lvl_q;
	logic [2:0]     req_s_q;
	logic           req_lvl_q;
	logic [BUS-1:0] next_q;
	logic           next_v_q;
	logic [BUS-1:0] cur_q;
	logic [1:0]     cyc_q;
	logic [3:0]     bit_q;
	logic [1:0]     still_q;
	logic           lclk_q;
	logic           frame_q;
	logic [NC-1:0]  lane_q;

	wire [5:0] cfg_w     = {fall_en, sdr_en, msb_en, wide_en, phase_w};
	wire [5:0] cfg_agree = cfg_s2_q ~^ cfg_s3_q;

	// Reset and settings are slow levels; they cross through three flops
	always_ff @(posedge ser_clk) begin
		rst_s_q   <= {rst_s_q[1:0], sys_rst};
		ser_rst_q <= (rst_s_q[1] == rst_s_q[2]) ? rst_s_q[2] : ser_rst_q;
		cfg_s1_q  <= cfg_w;
		cfg_s2_q  <= cfg_s1_q;
		cfg_s3_q  <= cfg_s2_q;
		req_s_q   <= {req_s_q[1:0], req_q};
	end

	wire [1:0] ph_s    = cfg_lvl_q[1:0];
	wire       wide_s  = cfg_lvl_q[2];
	wire       msb_s   = cfg_lvl_q[3];
	wire       sdr_s   = cfg_lvl_q[4];
	wire       fall_s  = cfg_lvl_q[5];
	wire [3:0] nbits   = wide_s ? ags_pkg::BITS_WIDE : ags_pkg::BITS_NARROW; // R15
	wire [3:0] half    = wide_s ? ags_pkg::HALF_WIDE : ags_pkg::HALF_NARROW;
	wire       last    = bit_q >= nbits - 4'd1;
	wire       bit_end = cyc_q[0];
	wire       got     = req_lvl_q != ack_q && !next_v_q;
	wire [3:0] idx     = msb_s ? nbits - 4'd1 - bit_q : bit_q; // R13 R14 R16
	wire [1:0] ddr_pos = cyc_q + 2'd2 - ph_s; // R6
	wire       ddr_clk = ddr_pos == 2'd1 || ddr_pos == 2'd2; // R5
	wire       sdr_clk = cyc_q[0] ^ fall_s; // R10
	wire       lclk_d  = sdr_s ? sdr_clk : ddr_clk; // R8
	wire       frame_d = bit_q < half;
	wire       first0  = msb_s ? cur_q[nbits - 4'd1] : cur_q[0];
	logic [NC-1:0] lane_d;

	for (genvar ln = 0; ln < NC; ln++) begin : g_lane
		assign lane_d[ln] = cur_q[ln*WW + 32'(idx)];
	end

	always_ff @(posedge ser_clk) begin
		if (ser_rst_q) begin
			cfg_lvl_q <= {1'b0, 1'b0, 1'b0, 1'b0, ags_pkg::PHASE_RST[ags_pkg::PHASE_LSB +: 2]};
			req_lvl_q <= 1'b0;
			ack_q     <= 1'b0;
			next_q    <= '0;
			next_v_q  <= 1'b0;
		end else begin
			cfg_lvl_q <= (cfg_agree & cfg_s3_q) | (~cfg_agree & cfg_lvl_q);
			req_lvl_q <= (req_s_q[1] == req_s_q[2]) ? req_s_q[2] : req_lvl_q;
			if (got) begin
				next_q   <= hold_q;
				next_v_q <= 1'b1;
				ack_q    <= req_lvl_q;
			end else if (bit_end && last) begin
				next_v_q <= 1'b0;
			end
		end
	end

	// Two ser_clk cycles per bit; an empty buffer sends zero words
	always_ff @(posedge ser_clk) begin
		if (ser_rst_q) begin
			cyc_q <= '0;
			bit_q <= '0;
			cur_q <= '0;
		end else begin
			cyc_q <= cyc_q + 2'd1;
			if (bit_end) begin
				bit_q <= last ? 4'd0 : bit_q + 4'd1;
				if (last) begin
					cur_q <= next_v_q ? next_q : '0;
				end
			end
		end
	end

	// All link outputs share one register stage, keeping them aligned
	always_ff @(posedge ser_clk) begin
		if (ser_rst_q) begin
			lclk_q  <= 1'b0;
			frame_q <= 1'b0;
			lane_q  <= '0;
			still_q <= '0;
		end else begin
			lclk_q  <= lclk_d;
			frame_q <= frame_d;
			lane_q  <= lane_d;
			still_q <= (cfg_lvl_q != cfg_s3_q || cfg_agree != 6'h3f) ? 2'd0
			           : (still_q == 2'd3) ? still_q : still_q + 2'd1;
		end
	end

	assign bit_clock_out        = lclk_q;
	assign frame_clock_positive = frame_q;
	assign lane_out             = lane_q;

	// ---------------- Checks ----------------
	gain_rst_a: assert property (@(posedge clk) sys_rst |=> gain_a_q == 16'h0000 && gain_b_q == 16'h0000) // R1
		else $error("gain not cleared by reset");
	gain_unity_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
		gain_code[0] == 4'h0 |-> gained[0] == sample_data[AW-1:0])
		else $error("zero gain code changed the sample");
	gain_map_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
		wr_en && wr_addr == ags_pkg::REG_GAIN_B |=> gain_code[7] == $past(wr_data[3:0]))
		else $error("channel eight gain not in low nibble");
	phase_rst_a: assert property (@(posedge clk) sys_rst |=> phase_w == 2'b10) // R6
		else $error("phase field not 10 after reset");
	mode_rst_a: assert property (@(posedge clk) sys_rst |=> !sdr_en && !msb_en && !twos_en) // R9
		else $error("output mode not default after reset");
	twos_msb_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
		twos_en && !pat_en && !wide_en |-> fmt[0][11] == !gained[0][AW-1])
		else $error("two's complement top bit wrong");
	wide_fmt_a: assert property (@(posedge clk) disable iff (sys_rst) // R15
		wide_en && !pat_en |-> !fmt[0][0] && fmt[0][13] == (gained[0][AW-1] ^ twos_en))
		else $error("14-bit word not padded");
	pattern_sel_a: assert property (@(posedge clk) disable iff (sys_rst) // R16
		pat_en && wide_en |-> fmt[0] == custom_w)
		else $error("custom word not placed");
	first_bit_a: assert property (@(posedge ser_clk) disable iff (ser_rst_q) // R13
		$rose(frame_clock_positive) |-> lane_out[0] == $past(first0))
		else $error("wrong first bit after frame rise");
	sdr_toggle_a: assert property (@(posedge ser_clk) disable iff (ser_rst_q) // R8
		sdr_s && still_q == 2'd3 |=> bit_clock_out != $past(bit_clock_out))
		else $error("single rate bit clock not toggling each cycle");
	ddr_period_a: assert property (@(posedge ser_clk) disable iff (ser_rst_q) // R5
		!sdr_s && still_q == 2'd3 |=> bit_clock_out == !$past(bit_clock_out, 2))
		else $error("double rate bit clock period wrong");
endmodule // ags_format_top

// [tb/ags_rx_model.sv]
module ags_rx_model (
	input wire logic       ser_clk,
	input wire logic       bit_clock_out,
	input wire logic       frame_clock_positive,
	input wire logic [7:0] lane_out,
	input wire logic       wide
);
	timeunit 1ns;
	timeprecision 1ps;
	int          cyc      = 64;
	int          word_cnt = 0;
	int          nb;
	logic        fr_prev  = 1'b1;
	logic [13:0] acc [8]     = '{default: '0};
	logic [13:0] rx_word [8] = '{default: '0};
	logic [13:0] ca_acc   = '0;
	logic [13:0] cb_acc   = '0;
	logic [13:0] clk_a    = '0;
	logic [13:0] clk_b    = '0;

	// Word boundary is the frame clock rising edge, bit 0 first
	always @(posedge ser_clk) begin
		nb = wide ? 14 : 12;
		cyc = (frame_clock_positive && !fr_prev) ? 0 : cyc + 1;
		fr_prev = frame_clock_positive;
		if (cyc < 2 * nb) begin
			if (cyc % 2 == 0) begin
				ca_acc[cyc / 2] = bit_clock_out;
			end else begin
				// Mid-window sample, where the chosen capture edge must sit
				cb_acc[cyc / 2] = bit_clock_out;
				for (int l = 0; l < 8; l++) acc[l][cyc / 2] = lane_out[l];
			end
		end
		if (cyc == 2 * nb - 1) begin
			rx_word = acc;
			clk_a = ca_acc;
			clk_b = cb_acc;
			word_cnt++;
			acc = '{default: '0};
			ca_acc = '0;
			cb_acc = '0;
		end
	end
endmodule // ags_rx_model

// [tb/tb_ags_format_top.sv]
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module tb_ags_format_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk = 1'b0;
	logic         ser_clk = 1'b0;
	logic         sys_rst, spi_sclk, spi_sdata, spi_cs_n, spi_sdout;
	logic         sample_valid, sample_ready, bit_clock_out, frame_clock_positive;
	logic [103:0] sample_data;
	logic [7:0]   lane_out;
	logic         wide;
	int           err_total = 0;
	int           n_tests   = 0;
	int           tick      = 0;

	always #5 clk = ~clk;
	// Link clock unrelated in phase to clk
	initial begin
		#3.3;
		forever #80 ser_clk = ~ser_clk;
	end

	ags_format_top ags_format_top_i (.clk(clk), .sys_rst(sys_rst), .ser_clk(ser_clk),
		.spi_sclk(spi_sclk), .spi_sdata(spi_sdata), .spi_cs_n(spi_cs_n), .spi_sdout(spi_sdout),
		.sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
		.bit_clock_out(bit_clock_out), .frame_clock_positive(frame_clock_positive),
		.lane_out(lane_out));

	ags_rx_model ags_rx_model_i (.ser_clk(ser_clk), .bit_clock_out(bit_clock_out),
		.frame_clock_positive(frame_clock_positive), .lane_out(lane_out), .wide(wide));

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk) begin
		tick++;
		if (tick == 95000) begin
			err_total++;
			conclude();
		end
	end

	// Sclk halves of 6 clk cover the 3-flop synchroniser
	task automatic spi(input logic [23:0] f, output logic [15:0] rd);
		@(negedge clk);
		spi_cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spi_sdata = f[i];
			repeat (6) @(negedge clk);
			if (i < 16) rd[i] = spi_sdout;
			spi_sclk = 1'b1;
			repeat (6) @(negedge clk);
			spi_sclk = 1'b0;
		end
		repeat (6) @(negedge clk);
		spi_cs_n = 1'b1;
		spi_sdata = ~spi_sdata;
		repeat (6) @(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] x;
		spi({1'b0, a[6:0], d}, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		spi({1'b1, a[6:0], 16'h0000}, d);
	endtask

	task automatic wait_words(input int n);
		int s;
		s = ags_rx_model_i.word_cnt;
		while (ags_rx_model_i.word_cnt < s + n) @(negedge clk);
	endtask

	// Word format is fixed before the buffer, so such changes need a full flush
	task automatic check_link(input logic [13:0] w, input logic [13:0] xr, input int nw);
		wait_words(nw);
		for (int l = 0; l < 8; l++) `CHK(ags_rx_model_i.rx_word[l], w)
		`CHK(ags_rx_model_i.clk_a ^ ags_rx_model_i.clk_b, xr)
	endtask

	initial begin
		logic [15:0] v;
		int          n;
		sys_rst = 1'b1;
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdata = 1'b0;
		sample_valid = 1'b0;
		sample_data = {8{13'h1064}};
		wide = 1'b0;
		// Longer than five ser_clk cycles (80 clk) so the link domain also sees reset
		repeat (110) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		rd(ags_pkg::REG_PHASE, v); `CHK(v, 16'h0040)
		rd(ags_pkg::REG_MODE, v); `CHK(v, 16'h0000)
		rd(ags_pkg::REG_GAIN_A, v); `CHK(v, 16'h0000)
		rd(ags_pkg::REG_GAIN_B, v); `CHK(v, 16'h0000)
		wr(8'h11, 16'hffff);
		rd(8'h11, v); `CHK(v, 16'h0000)
		// Fill the buffer until refused, then let the link drain it
		sample_valid = 1'b1;
		n = 0;
		while (sample_ready === 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		sample_valid = 1'b0;
		`CHK(n >= 16 && n <= 17, 1'b1)
		rd(ags_pkg::REG_STATUS, v); `CHK(v[1], 1'b1)
		n = 0;
		while (v[1] !== 1'b0 && n < 60) begin
			rd(ags_pkg::REG_STATUS, v);
			n++;
		end
		`CHK(v[1], 1'b0)
		// Constant stream from here on
		sample_valid = 1'b1;
		check_link(14'h0832, 14'h0fff, 3);
		`CHK((ags_rx_model_i.clk_b ^ (ags_rx_model_i.clk_b >> 1)) & 14'h07ff, 14'h07ff)
		wr(ags_pkg::REG_MODE, 16'h0004);
		check_link(14'h0032, 14'h0fff, 21);
		wr(ags_pkg::REG_MODE, 16'h0008);
		check_link(14'h04c1, 14'h0fff, 21);
		wr(ags_pkg::REG_WIDTH, 16'h0002);
		wide = 1'b1;
		wr(ags_pkg::REG_MODE, 16'h000c);
		check_link(14'h04c0, 14'h3fff, 21);
		wr(ags_pkg::REG_WIDTH, 16'h0000);
		wide = 1'b0;
		wr(ags_pkg::REG_MODE, 16'h0008);
		wr(ags_pkg::REG_CUSTOM_ONE, 16'hb4e8);
		wr(ags_pkg::REG_PATTERN_MODE, 16'h0010);
		check_link(14'h072d, 14'h0fff, 21);
		wr(ags_pkg::REG_PATTERN_MODE, 16'h0000);
		// Sample rate here is far below the SDR ceiling
		wr(ags_pkg::REG_MODE, 16'h0010);
		check_link(14'h0832, 14'h0fff, 21);
		`CHK(ags_rx_model_i.clk_b, 14'h0fff)
		wr(ags_pkg::REG_MODE, 16'h2010);
		check_link(14'h0832, 14'h0fff, 3);
		`CHK(ags_rx_model_i.clk_b, 14'h0000)
		wr(ags_pkg::REG_MODE, 16'h0000);
		wr(ags_pkg::REG_PHASE, 16'h0020);
		check_link(14'h0832, 14'h0000, 3);
		wr(ags_pkg::REG_PHASE, 16'h0040);
		// Gain codes kept within 0 to 12 dB
		wr(ags_pkg::REG_GAIN_A, 16'h0006);
		wr(ags_pkg::REG_GAIN_B, 16'h000c);
		rd(ags_pkg::REG_GAIN_A, v); `CHK(v, 16'h0006)
		// Gain may sit ahead of the buffer, so let it flush
		wait_words(21);
		for (int l = 0; l < 8; l++)
			`CHK(ags_rx_model_i.rx_word[l], l == 0 ? 14'h0863 : l == 7 ? 14'h08c7 : 14'h0832)
		conclude();
	end
endmodule // tb_ags_format_top
